/* logic/mdsf_status.sv */
// mdsf_status: driver status word, read-only, with short and thermal latches
// assumes: monitor inputs are synchronous levels from the detector circuits;
// register read port is the device's internal serial register access
`timescale 1ns/10ps
module mdsf_status #(
   parameter int IDLE_LOG2 = mdsf_pkg::MDSF_STANDSTILL_LOG2
) (
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   input  wire logic                  step_pulse,
   input  wire mdsf_pkg::mdsf_short_type short_detect,
   input  wire mdsf_pkg::mdsf_mon_type   mon,
   input  wire logic [3:0]            off_time_setting,
   input  wire logic                  driver_enable_n_input,
   input  wire logic                  enable_n_pin,
   input  wire logic                  reg_rd,
   input  wire logic                  reg_wr,
   input  wire logic [6:0]            reg_addr,
   input  wire logic [31:0]           reg_wdata,
   output logic [31:0]                reg_rdata,
   output logic                       driver_disable,
   output logic                       stall_out
);
   import mdsf_pkg::*;

   //-----------------------------------------------------------------
   // state
   //-----------------------------------------------------------------
   mdsf_short_type    shorts_ff;
   mdsf_short_type    nxt_shorts;
   mdsf_ot_state_type ot_ff;
   mdsf_ot_state_type nxt_ot;
   logic [31:0]       status_ff;
   logic [31:0]       nxt_status;
   logic [31:0]       rdata_ff;
   logic [31:0]       nxt_rdata;
   logic              disable_ff;
   logic              nxt_disable;
   logic              stall_ff;
   logic              nxt_stall;
   logic              idle;
   logic              gnd_clear;
   logic              sup_clear;

   mdsf_idle_timer #(.CNT_W(IDLE_LOG2)) u_idle (
      .ref_clk      (ref_clk),
      .rst          (rst),
      .step_pulse   (step_pulse),
      .idle_reached (idle)
   );

   //-----------------------------------------------------------------
   // short latches
   //-----------------------------------------------------------------
   // ground shorts clear on off-time zero or the driver enable input
   assign gnd_clear = (off_time_setting == 4'h0) || driver_enable_n_input;
   // supply shorts clear on off-time zero or the enable pin
   assign sup_clear = (off_time_setting == 4'h0) || enable_n_pin;

   // detection wins over a clear in the same cycle
   always_comb begin
      nxt_shorts.gnd_b = short_detect.gnd_b | (shorts_ff.gnd_b & ~gnd_clear);
      nxt_shorts.gnd_a = short_detect.gnd_a | (shorts_ff.gnd_a & ~gnd_clear);
      nxt_shorts.sup_b = short_detect.sup_b | (shorts_ff.sup_b & ~sup_clear);
      nxt_shorts.sup_a = short_detect.sup_a | (shorts_ff.sup_a & ~sup_clear);
   end

   //-----------------------------------------------------------------
   // thermal shutdown
   //-----------------------------------------------------------------
   // shutdown holds until the pre-warning has cleared by cooling
   always_comb begin
      nxt_ot = ot_ff;
      unique case (ot_ff)
         MDSF_OT_NORMAL: begin
            if (mon.ot_limit)
               nxt_ot = MDSF_OT_SHUTDOWN;
         end
         MDSF_OT_SHUTDOWN: begin
            if (!mon.ot_limit && !mon.ot_prewarn)
               nxt_ot = MDSF_OT_NORMAL;
         end
      endcase
   end

   //-----------------------------------------------------------------
   // status word assembly
   //-----------------------------------------------------------------
   // unused bits stay zero; open-load flags drive nothing else
   always_comb begin
      nxt_status                      = MDSF_RESET_STATUS;
      nxt_status[MDSF_BIT_STANDSTILL] = idle;
      nxt_status[MDSF_BIT_OPEN_B]     = mon.open_b;
      nxt_status[MDSF_BIT_OPEN_A]     = mon.open_a;
      nxt_status[MDSF_BIT_SGND_B]     = nxt_shorts.gnd_b;
      nxt_status[MDSF_BIT_SGND_A]     = nxt_shorts.gnd_a;
      nxt_status[MDSF_BIT_OTPREWARN]  = mon.ot_prewarn;
      nxt_status[MDSF_BIT_OTSHUT]     = (nxt_ot == MDSF_OT_SHUTDOWN);
      nxt_status[MDSF_BIT_STALL]      = nxt_stall;
      nxt_status[MDSF_CS_LSB +: MDSF_CS_W] = mon.cur_scale;
      nxt_status[MDSF_BIT_FULLSTEP]   = mon.full_step;
      nxt_status[MDSF_BIT_QUIET]      = mon.quiet_mode;
      nxt_status[MDSF_BIT_SSUP_B]     = nxt_shorts.sup_b;
      nxt_status[MDSF_BIT_SSUP_A]     = nxt_shorts.sup_a;
      nxt_status[MDSF_LOAD_W-1:0]     = mon.load_value;
   end

   // stall source follows the active chopper mode
   always_comb begin
      if (mon.commut_mode)
         nxt_stall = mon.stall_commut;
      else if (mon.quiet_mode)
         nxt_stall = mon.stall_quiet;
      else
         nxt_stall = mon.stall_classic || (mon.load_value == '0);
   end

   // any short or thermal shutdown keeps the bridges off
   assign nxt_disable = (|nxt_shorts) || (nxt_ot == MDSF_OT_SHUTDOWN);

   // read port: only the status address answers; writes are dropped
   always_comb begin
      nxt_rdata = rdata_ff;
      if (reg_rd)
         nxt_rdata = (reg_addr == MDSF_ADDR_STATUS) ? status_ff : 32'h0000_0000;
   end

   //-----------------------------------------------------------------
   // registers
   //-----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         shorts_ff  <= '0;
         ot_ff      <= MDSF_OT_NORMAL;
         status_ff  <= MDSF_RESET_STATUS;
         rdata_ff   <= 32'h0000_0000;
         disable_ff <= 1'b0;
         stall_ff   <= 1'b0;
      end else begin
         shorts_ff  <= nxt_shorts;
         ot_ff      <= nxt_ot;
         status_ff  <= nxt_status;
         rdata_ff   <= nxt_rdata;
         disable_ff <= nxt_disable;
         stall_ff   <= nxt_stall;
      end
   end

   assign reg_rdata      = rdata_ff;
   assign driver_disable = disable_ff;
   assign stall_out      = stall_ff;

   //-----------------------------------------------------------------
   // checks
   //-----------------------------------------------------------------
   sequence s_gnd_b_hit;
      short_detect.gnd_b;
   endsequence

   a_idle_after_step: assert property (@(posedge ref_clk) disable iff (rst)
      step_pulse |=> ##1 !status_ff[MDSF_BIT_STANDSTILL])
      else $error("standstill flag set right after step");
   a_open_passthru: assert property (@(posedge ref_clk) disable iff (rst)
      status_ff[MDSF_BIT_OPEN_B] == $past(mon.open_b) &&
      status_ff[MDSF_BIT_OPEN_A] == $past(mon.open_a))
      else $error("open load flags wrong");
   // flag and bridge disable both show one edge after the hit
   a_gnd_latch: assert property (@(posedge ref_clk) disable iff (rst)
      s_gnd_b_hit |=> status_ff[MDSF_BIT_SGND_B] && driver_disable)
      else $error("ground short not latched");
   a_gnd_hold: assert property (@(posedge ref_clk) disable iff (rst)
      status_ff[MDSF_BIT_SGND_A] && !gnd_clear |=> status_ff[MDSF_BIT_SGND_A])
      else $error("ground short flag dropped");
   a_sup_hold: assert property (@(posedge ref_clk) disable iff (rst)
      shorts_ff.sup_b && !sup_clear |=> shorts_ff.sup_b && status_ff[MDSF_BIT_SSUP_B])
      else $error("supply short flag dropped");
   a_prewarn: assert property (@(posedge ref_clk) disable iff (rst)
      status_ff[MDSF_BIT_OTPREWARN] == $past(mon.ot_prewarn))
      else $error("pre-warning flag wrong");
   a_ot_hold: assert property (@(posedge ref_clk) disable iff (rst)
      ot_ff == MDSF_OT_SHUTDOWN && mon.ot_prewarn |=> ot_ff == MDSF_OT_SHUTDOWN)
      else $error("shutdown released while warm");
   a_stall_zero: assert property (@(posedge ref_clk) disable iff (rst)
      !mon.commut_mode && !mon.quiet_mode && mon.load_value == '0 |=> stall_out)
      else $error("zero load value did not flag stall");
   a_cs_field: assert property (@(posedge ref_clk) disable iff (rst)
      status_ff[MDSF_CS_LSB +: MDSF_CS_W] == $past(mon.cur_scale))
      else $error("current scale field wrong");
   a_modes: assert property (@(posedge ref_clk) disable iff (rst)
      status_ff[MDSF_BIT_FULLSTEP] == $past(mon.full_step) &&
      status_ff[MDSF_BIT_QUIET] == $past(mon.quiet_mode))
      else $error("mode indicator wrong");
   a_unused_zero: assert property (@(posedge ref_clk) disable iff (rst)
      reg_rd |=> reg_rdata[23:21] == 3'h0 && reg_rdata[11:10] == 2'h0)
      else $error("unused bits not zero");
   // a write alone never disturbs the read data
   a_write_ignored: assert property (@(posedge ref_clk) disable iff (rst)
      reg_wr && !reg_rd |=> $stable(reg_rdata))
      else $error("write changed read data");
   // commutation mode takes its own stall source
   a_stall_commut: assert property (@(posedge ref_clk) disable iff (rst)
      mon.commut_mode |=> stall_out == $past(mon.stall_commut))
      else $error("commutation stall not reported");

endmodule : mdsf_status

/* logic/mdsf_pkg.sv */
// mdsf_pkg: constants and carrier types of the driver status word block
// assumes: one clock domain, register read port driven by the serial interface
package mdsf_pkg;

   //--------------------------------------------------------------
   // register map
   //--------------------------------------------------------------
   localparam logic [6:0]  MDSF_ADDR_STATUS    = 7'h6F;
   localparam logic [31:0] MDSF_RESET_STATUS   = 32'h0000_0000;

   //--------------------------------------------------------------
   // field positions
   //--------------------------------------------------------------
   localparam int MDSF_BIT_STANDSTILL  = 31;
   localparam int MDSF_BIT_OPEN_B      = 30;
   localparam int MDSF_BIT_OPEN_A      = 29;
   localparam int MDSF_BIT_SGND_B      = 28;
   localparam int MDSF_BIT_SGND_A      = 27;
   localparam int MDSF_BIT_OTPREWARN   = 26;
   localparam int MDSF_BIT_OTSHUT      = 25;
   localparam int MDSF_BIT_STALL       = 24;
   localparam int MDSF_CS_LSB          = 16;
   localparam int MDSF_CS_W            = 5;
   localparam int MDSF_BIT_FULLSTEP    = 15;
   localparam int MDSF_BIT_QUIET       = 14;
   localparam int MDSF_BIT_SSUP_B      = 13;
   localparam int MDSF_BIT_SSUP_A      = 12;
   localparam int MDSF_LOAD_W          = 10;

   //--------------------------------------------------------------
   // timing
   //--------------------------------------------------------------
   localparam int MDSF_STANDSTILL_LOG2 = 20; // idle clocks = 2^20
   localparam int MDSF_STANDSTILL_CYC  = 1 << MDSF_STANDSTILL_LOG2;

   //--------------------------------------------------------------
   // carriers
   //--------------------------------------------------------------
   typedef struct packed {
      logic       gnd_b;
      logic       gnd_a;
      logic       sup_b;
      logic       sup_a;
   } mdsf_short_type;

   typedef struct packed {
      logic                   open_b;
      logic                   open_a;
      logic                   ot_prewarn;
      logic                   ot_limit;
      logic                   stall_quiet;   // stall by quiet-mode load method
      logic                   stall_classic; // stall by classic load method
      logic                   stall_commut;  // stall by automatic commutation
      logic                   commut_mode;
      logic                   full_step;
      logic                   quiet_mode;
      logic [MDSF_CS_W-1:0]   cur_scale;
      logic [MDSF_LOAD_W-1:0] load_value;
   } mdsf_mon_type;

   typedef enum logic [1:0] {
      MDSF_OT_NORMAL,
      MDSF_OT_SHUTDOWN
   } mdsf_ot_state_type;

endpackage : mdsf_pkg

/* logic/mdsf_idle_timer.sv */
// mdsf_idle_timer: counts clocks since the last step pulse
// assumes: step pulse is synchronous to ref_clk
`timescale 1ns/10ps
module mdsf_idle_timer #(
   parameter int CNT_W = 20
) (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic step_pulse,
   output logic      idle_reached
);
   import mdsf_pkg::*;

   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic             idle_ff;
   logic             nxt_idle;

   //-----------------------------------------------------------------
   // counter
   //-----------------------------------------------------------------
   // count wraps to zero as idle is flagged, then holds; a step restarts it
   always_comb begin
      nxt_cnt  = cnt_ff;
      nxt_idle = idle_ff;
      if (step_pulse) begin
         nxt_cnt  = '0;
         nxt_idle = 1'b0;
      end else if (!idle_ff) begin
         nxt_cnt = cnt_ff + 1'b1;
         if (&cnt_ff)
            nxt_idle = 1'b1; // 2^CNT_W idle clocks elapsed
      end
   end

   // registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cnt_ff  <= '0;
         idle_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         idle_ff <= nxt_idle;
      end
   end

   assign idle_reached = idle_ff;

endmodule : mdsf_idle_timer

/* test/testbench.sv */
// testbench: self-checking bench for the driver status word block
// assumes: mdsf_pkg compiled first; design ports driven here, no partner model
`timescale 1ns/10ps
`define CHECK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin bad_count++; \
   $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module testbench;
   import mdsf_pkg::*;
   localparam int IDLE = 4; // shortened standstill count as log2 (2^4 = 16 clocks)
   logic           ref_clk          = 1'b0;
   logic           rst              = 1'b1;
   logic           step_pulse       = 1'b0;
   logic           den              = 1'b0;
   logic           epin             = 1'b0;
   logic           reg_rd           = 1'b0;
   logic           reg_wr           = 1'b0;
   logic [3:0]     off_time_setting = 4'h5;
   logic [6:0]     reg_addr         = 7'h00;
   logic [31:0]    reg_wdata        = 32'h0000_0000;
   logic [31:0]    reg_rdata;
   logic           driver_disable;
   logic           stall_out;
   mdsf_short_type short_detect     = '0;
   mdsf_mon_type   mon              = '0;
   mdsf_short_type sd;
   mdsf_mon_type   mv;
   logic [31:0]    r;
   int             bad_count        = 0;
   int             total_checks     = 0;
   int             seed             = 6;
   int             idle             = 0;
   bit             m_gb, m_ga, m_sb, m_sa, m_ot;

   //---------------------------------------------------------------
   // clock, design and idle model
   //---------------------------------------------------------------
   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) idle <= (rst || step_pulse) ? 0 : idle + 1;

   mdsf_status #(.IDLE_LOG2(IDLE)) DUT (
      .ref_clk(ref_clk), .rst(rst), .step_pulse(step_pulse), .short_detect(short_detect),
      .mon(mon), .off_time_setting(off_time_setting), .driver_enable_n_input(den),
      .enable_n_pin(epin), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .driver_disable(driver_disable),
      .stall_out(stall_out));

   //---------------------------------------------------------------
   // model and bus tasks
   //---------------------------------------------------------------
   // expected status word from model state and present inputs
   function automatic logic [31:0] exp_word();
      logic st;
      st = mon.commut_mode ? mon.stall_commut : mon.quiet_mode ? mon.stall_quiet :
           (mon.stall_classic | (mon.load_value == 10'h000));
      return {idle > (1 << IDLE), mon.open_b, mon.open_a, m_gb, m_ga, mon.ot_prewarn, m_ot,
              st, 3'h0, mon.cur_scale, mon.full_step, mon.quiet_mode, m_sb, m_sa, 2'h0,
              mon.load_value};
   endfunction : exp_word

   // one read strobe, data compared once it stands; model sampled at the taking edge
   task automatic read_chk(input logic [6:0] a, input logic [31:0] ex_in, input bit use_model);
      logic [31:0] ex;
      ex = ex_in;
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      if (use_model) ex = exp_word();
      @(posedge ref_clk);
      #1;
      `CHECK("status", ex, reg_rdata)
   endtask : read_chk

   // drive inputs, let them settle, update model, read and compare
   task automatic apply(input mdsf_short_type s, input mdsf_mon_type m, input logic [3:0] t,
                        input logic dn, input logic ep);
      logic [31:0] ex;
      @(posedge ref_clk);
      short_detect     <= s;
      mon              <= m;
      off_time_setting <= t;
      den              <= dn;
      epin             <= ep;
      repeat (3) @(posedge ref_clk);
      m_gb = s.gnd_b | (m_gb & (t != 4'h0) & !dn);
      m_ga = s.gnd_a | (m_ga & (t != 4'h0) & !dn);
      m_sb = s.sup_b | (m_sb & (t != 4'h0) & !ep);
      m_sa = s.sup_a | (m_sa & (t != 4'h0) & !ep);
      m_ot = m.ot_limit | (m_ot & m.ot_prewarn);
      ex = exp_word();
      read_chk(MDSF_ADDR_STATUS, ex, 1'b1);
      `CHECK("disable", m_gb | m_ga | m_sb | m_sa | m_ot, driver_disable)
      `CHECK("stall", ex[24], stall_out)
   endtask : apply

   // counts, verdict and end of run
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : conclude

   //---------------------------------------------------------------
   // watchdog and main sequence
   //---------------------------------------------------------------
   initial begin
      #150000;
      bad_count++;
      conclude();
   end

   initial begin
      repeat (5) @(posedge ref_clk);
      #1;
      `CHECK("rst data", 32'h0000_0000, reg_rdata)
      `CHECK("rst disable", 1'b0, driver_disable)
      @(posedge ref_clk);
      rst <= 1'b0;
      repeat (40) @(posedge ref_clk);
      $display("test reset done");
      sd = '0;
      mv = '0;
      mv.load_value = 10'h155;
      @(posedge ref_clk);
      step_pulse <= 1'b1;
      @(posedge ref_clk);
      step_pulse <= 1'b0;
      apply(sd, mv, 4'h5, 1'b0, 1'b0);
      repeat (30) @(posedge ref_clk);
      apply(sd, mv, 4'h5, 1'b0, 1'b0);
      // read lands just before and just after the standstill threshold
      for (int k = 10; k < 14; k++) begin
         @(posedge ref_clk);
         step_pulse <= 1'b1;
         @(posedge ref_clk);
         step_pulse <= 1'b0;
         repeat (k) @(posedge ref_clk);
         apply(sd, mv, 4'h5, 1'b0, 1'b0);
      end
      $display("test standstill done");
      sd = 4'hF;
      apply(sd, mv, 4'h5, 1'b0, 1'b0);
      sd = '0;
      apply(sd, mv, 4'h5, 1'b0, 1'b1);
      apply(sd, mv, 4'h5, 1'b1, 1'b0);
      sd = 4'hF;
      apply(sd, mv, 4'h0, 1'b0, 1'b0);
      sd = '0;
      apply(sd, mv, 4'h0, 1'b0, 1'b0);
      $display("test shorts done");
      mv.ot_limit   = 1'b1;
      mv.ot_prewarn = 1'b1;
      apply(sd, mv, 4'h5, 1'b0, 1'b0);
      mv.ot_limit = 1'b0;
      apply(sd, mv, 4'h5, 1'b0, 1'b0);
      mv.ot_prewarn = 1'b0;
      apply(sd, mv, 4'h5, 1'b0, 1'b0);
      $display("test thermal done");
      for (int i = 0; i < 16; i++) begin
         {mv.commut_mode, mv.quiet_mode, mv.stall_commut, mv.stall_quiet} = 4'(i);
         mv.stall_classic = 1'b0;
         mv.load_value    = (i % 2) ? 10'h000 : 10'h3FF;
         apply(sd, mv, 4'h5, 1'b0, 1'b0);
      end
      $display("test stall modes done");
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_wdata <= 32'hFFFF_FFFF;
      reg_addr  <= MDSF_ADDR_STATUS;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      apply(sd, mv, 4'h5, 1'b0, 1'b0);
      read_chk(7'h6E, 32'h0000_0000, 1'b0);
      $display("test write and unmapped done");
      for (int i = 0; i < 150; i++) begin
         r  = $random(seed);
         mv = r[$bits(mdsf_mon_type)-1:0];
         if (($random(seed) & 3) == 0) mv.load_value = 10'h000;
         r  = $random(seed);
         sd = ((r & 7) == 0) ? r[7:4] : 4'h0;
         r  = $random(seed);
         apply(sd, mv, ((r & 7) == 0) ? 4'h0 : r[7:4], r[8] & r[9], r[10] & r[11]);
      end
      $display("test random done");
      conclude();
   end
endmodule : testbench
